// [include/sfc_pkg.sv]
// ==========================================================
// Serial flash command core constants and types
// ==========================================================
package sfc_pkg;

   // ==========================================================
   // Array geometry and FIFO depth
   // ==========================================================
   localparam int ADDR_W = 20;
   localparam int BLK_LSB = 16;
   localparam int SEC_LSB = 12;
   localparam int WORD_STEP = 2;
   localparam int FIFO_DEPTH = 16;

   // ==========================================================
   // Opcodes
   // ==========================================================
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_FAST_READ = 8'h0B;
   localparam logic [7:0] OPC_BYTE_PROG = 8'h02;
   localparam logic [7:0] OPC_WORD_PROG = 8'hAD;
   localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ = 8'h05;
   localparam logic [7:0] OPC_BUSY_OUT_ON = 8'h70;
   localparam logic [7:0] OPC_BUSY_OUT_OFF = 8'h80;
   localparam logic [7:0] OPC_BLOCK_ERASE = 8'hD8;
   localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;

   // ==========================================================
   // Status byte layout, reset value and serial count limits
   // ==========================================================
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_AAI_BIT = 6;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_LAST = 2'h2;

   // ==========================================================
   // Self-timed operation durations
   // ==========================================================
   localparam longint CLK_MHZ = 125;
   localparam longint PROGRAM_TIME_US = 10;
   localparam longint SECTOR_ERASE_TIME_MS = 100;
   localparam longint BLOCK_ERASE_TIME_MS = 1000;
   localparam longint CHIP_ERASE_TIME_MS = 10000;
   localparam longint PROGRAM_CYC = PROGRAM_TIME_US * CLK_MHZ;
   localparam longint SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam longint BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam longint CHIP_ERASE_CYC = CHIP_ERASE_TIME_MS * 1000 * CLK_MHZ;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      OPK_BYTE = 3'b000,
      OPK_WORD = 3'b001,
      OPK_SECTOR = 3'b010,
      OPK_BLOCK = 3'b011,
      OPK_CHIP = 3'b100
   } sfc_opk_t;

   typedef struct packed {
      sfc_opk_t kind;
      logic [23:0] addr;
      logic [15:0] data;
   } sfc_op_t;

   typedef enum logic [2:0] {
      SS_CMD = 3'b000,
      SS_ADDR = 3'b001,
      SS_DUMMY = 3'b010,
      SS_RXDATA = 3'b011,
      SS_TX = 3'b100,
      SS_SKIP = 3'b101
   } sfc_ser_t;

endpackage : sfc_pkg

// [core/sfc_core.sv]

// ==========================================================
// Operation FIFO toward the array backend
// ==========================================================
module sfc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Honest flags straight from the count
   assign in_ready = (cnt_q != CNT_FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   // Storage has no reset; only the pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : sfc_fifo

// ==========================================================
// Serial flash command core
// ==========================================================
module sfc_core
   import sfc_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int NUM_BLK = 2 ** (ADDR_W - BLK_LSB),
   parameter longint PROG_CYC = PROGRAM_CYC,
   parameter longint SEC_CYC = SECTOR_ERASE_CYC,
   parameter longint BLK_CYC = BLOCK_ERASE_CYC,
   parameter longint CHIP_CYC = CHIP_ERASE_CYC
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Serial link, sampled on CORE_CLK
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SI,
   output logic SO,
   output logic SO_OE,
   // Array read port, data one cycle after address
   output logic [AW-1:0] MEM_RD_ADDR,
   input wire logic [7:0] MEM_RD_DATA,
   // Program and erase operations toward the array
   output logic OP_VALID,
   input wire logic OP_READY,
   output sfc_op_t OP_DATA,
   // Protection and status
   input wire logic [NUM_BLK-1:0] PROT_MASK,
   output logic BUSY,
   output logic WRITE_ENABLE_LATCH,
   output logic AAI_ACTIVE
);

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic is_prot(input logic [NUM_BLK-1:0] m, input logic [AW-1:0] a);
      return m[a[AW-1:BLK_LSB]];
   endfunction : is_prot

   function automatic logic [AW-1:0] align(input logic [AW-1:0] a, input int lsb);
      return (a >> lsb) << lsb;
   endfunction : align

   // ==========================================================
   // State
   // ==========================================================
   sfc_ser_t state_q;
   logic sck_q;
   logic cs_n_q;
   logic [2:0] bitcnt_q;
   logic [2:0] txcnt_q;
   logic [1:0] acnt_q;
   logic [6:0] sh_q;
   logic [7:0] op_q;
   logic [AW-1:0] addr_q;
   logic [7:0] d0_q;
   logic [7:0] d1_q;
   logic dsec_q;
   logic done_q;
   logic [7:0] tx_q;
   logic sobit_q;
   logic so_q;
   logic so_oe_q;
   logic wel_q;
   logic aai_q;
   logic busy_out_q;
   logic [AW-1:0] aai_addr_q;
   logic pend_q;
   sfc_op_t pend_op_q;
   logic [31:0] tmr_q;
   logic fifo_in_ready;
   logic fifo_out_valid;

   // ==========================================================
   // Edge detection and decode
   // ==========================================================
   // Sampling limits the link to well below half the core rate
   wire cs_low = !CS_N;
   wire sck_rise = cs_low && SCK && !sck_q;
   wire sck_fall = cs_low && !SCK && sck_q;
   wire cs_rise = CS_N && !cs_n_q;
   wire byte_done = sck_rise && (bitcnt_q == BIT_LAST);
   wire [7:0] rx = {sh_q, SI};
   wire busy = pend_q || (tmr_q != '0) || fifo_out_valid;
   wire busy_ind = cs_low && busy_out_q && aai_q;
   wire is_status = (op_q == OPC_STATUS_READ);
   wire is_chip = (op_q == OPC_CHIP_ERASE_A) || (op_q == OPC_CHIP_ERASE_B);
   wire [AW-1:0] waddr = aai_q ? aai_addr_q : {addr_q[AW-1:1], 1'b0};
   wire [AW-1:0] wnext = waddr + AW'(WORD_STEP);
   wire word_last = (waddr[AW-1:1] == '1) || is_prot(PROT_MASK, wnext);
   wire commit = cs_rise && done_q && !busy;
   wire push = pend_q && fifo_in_ready;

   // Status byte seen by status reads
   logic [7:0] status;
   always_comb begin
      status = STAT_RESET;
      status[STAT_BUSY_BIT] = busy;
      status[STAT_WEL_BIT] = wel_q;
      status[STAT_AAI_BIT] = aai_q;
   end
   wire [7:0] tx_load = is_status ? status : MEM_RD_DATA;

   // ==========================================================
   // Serial receive and transmit
   // ==========================================================
   // Deselect clears the sequence; done_q is still valid at the rise
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= SS_CMD;
         bitcnt_q <= '0;
         txcnt_q <= '0;
         acnt_q <= '0;
         sh_q <= '0;
         op_q <= '0;
         addr_q <= '0;
         d0_q <= '0;
         d1_q <= '0;
         dsec_q <= 1'b0;
         done_q <= 1'b0;
         tx_q <= '0;
         sobit_q <= 1'b0;
      end else if (!cs_low) begin
         state_q <= SS_CMD;
         bitcnt_q <= '0;
         txcnt_q <= '0;
         done_q <= 1'b0;
      end else if (sck_rise) begin
         sh_q <= rx[6:0];
         bitcnt_q <= bitcnt_q + 3'h1;
         if (byte_done) begin
            case (state_q)
               SS_CMD: begin
                  op_q <= rx;
                  acnt_q <= '0;
                  dsec_q <= 1'b0;
                  if (aai_q) begin
                     // Only three commands live inside a word sequence
                     if (rx == OPC_WORD_PROG) begin
                        state_q <= SS_RXDATA;
                     end else if (rx == OPC_STATUS_READ) begin
                        state_q <= SS_TX;
                     end else begin
                        done_q <= (rx == OPC_WRITE_DISABLE);
                        state_q <= SS_SKIP;
                     end
                  end else begin
                     case (rx)
                        OPC_READ, OPC_FAST_READ, OPC_BYTE_PROG, OPC_WORD_PROG,
                        OPC_SECTOR_ERASE, OPC_BLOCK_ERASE: begin
                           state_q <= SS_ADDR;
                        end
                        OPC_STATUS_READ: begin
                           state_q <= SS_TX;
                        end
                        OPC_WRITE_ENABLE, OPC_WRITE_DISABLE, OPC_BUSY_OUT_ON, OPC_BUSY_OUT_OFF,
                        OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
                           done_q <= 1'b1;
                           state_q <= SS_SKIP;
                        end
                        default: begin
                           state_q <= SS_SKIP;
                        end
                     endcase
                  end
               end
               SS_ADDR: begin
                  addr_q <= {addr_q[AW-9:0], rx};
                  acnt_q <= acnt_q + 2'h1;
                  if (acnt_q == ADDR_LAST) begin
                     case (op_q)
                        OPC_READ: state_q <= SS_TX;
                        OPC_FAST_READ: state_q <= SS_DUMMY;
                        OPC_BYTE_PROG, OPC_WORD_PROG: state_q <= SS_RXDATA;
                        default: begin
                           done_q <= 1'b1;
                           state_q <= SS_SKIP;
                        end
                     endcase
                  end
               end
               SS_DUMMY: begin
                  state_q <= SS_TX;
               end
               SS_RXDATA: begin
                  if (!dsec_q) begin
                     d0_q <= rx;
                     dsec_q <= 1'b1;
                     if (op_q == OPC_BYTE_PROG) begin
                        done_q <= 1'b1;
                        state_q <= SS_SKIP;
                     end
                  end else begin
                     d1_q <= rx;
                     done_q <= 1'b1;
                     state_q <= SS_SKIP;
                  end
               end
               SS_TX, SS_SKIP: begin
                  state_q <= state_q;
               end
               default: begin
                  state_q <= SS_SKIP;
               end
            endcase
         end
      end else if (sck_fall && (state_q == SS_TX)) begin
         txcnt_q <= txcnt_q + 3'h1;
         if (txcnt_q == '0) begin
            // Status repeats; array data advances and wraps by width
            sobit_q <= tx_load[7];
            tx_q <= {tx_load[6:0], 1'b0};
            if (!is_status) begin
               addr_q <= addr_q + 1'b1;
            end
         end else begin
            sobit_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Output pin, busy indication takes priority over data
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         sck_q <= SCK;
         cs_n_q <= CS_N;
         so_q <= busy_ind ? !busy : sobit_q;
         so_oe_q <= cs_low && (busy_ind || (state_q == SS_TX));
      end
   end

   // ==========================================================
   // Command commit at deselect
   // ==========================================================
   // Nothing is accepted while busy, which also covers a full FIFO
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wel_q <= 1'b0;
         aai_q <= 1'b0;
         busy_out_q <= 1'b0;
         aai_addr_q <= '0;
         pend_q <= 1'b0;
         pend_op_q <= '0;
      end else begin
         if (push) begin
            pend_q <= 1'b0;
         end
         if (commit) begin
            case (op_q)
               OPC_WRITE_ENABLE: wel_q <= 1'b1;
               OPC_WRITE_DISABLE: begin
                  wel_q <= 1'b0;
                  aai_q <= 1'b0;
               end
               OPC_BUSY_OUT_ON: busy_out_q <= 1'b1;
               OPC_BUSY_OUT_OFF: busy_out_q <= 1'b0;
               OPC_BYTE_PROG: begin
                  if (wel_q && !is_prot(PROT_MASK, addr_q)) begin
                     pend_q <= 1'b1;
                     pend_op_q <= '{kind: OPK_BYTE, addr: 24'(addr_q), data: {8'h00, d0_q}};
                     wel_q <= 1'b0;
                  end
               end
               OPC_WORD_PROG: begin
                  if (aai_q || (wel_q && !is_prot(PROT_MASK, waddr))) begin
                     pend_q <= 1'b1;
                     pend_op_q <= '{kind: OPK_WORD, addr: 24'(waddr), data: {d0_q, d1_q}};
                     aai_addr_q <= wnext;
                     aai_q <= !word_last;
                     wel_q <= !word_last;
                  end
               end
               OPC_SECTOR_ERASE: begin
                  if (wel_q && !is_prot(PROT_MASK, addr_q)) begin
                     pend_q <= 1'b1;
                     pend_op_q <= '{kind: OPK_SECTOR, addr: 24'(align(addr_q, SEC_LSB)), data: '0};
                     wel_q <= 1'b0;
                  end
               end
               OPC_BLOCK_ERASE: begin
                  if (wel_q && !is_prot(PROT_MASK, addr_q)) begin
                     pend_q <= 1'b1;
                     pend_op_q <= '{kind: OPK_BLOCK, addr: 24'(align(addr_q, BLK_LSB)), data: '0};
                     wel_q <= 1'b0;
                  end
               end
               default: begin
                  if (is_chip && wel_q && (PROT_MASK == '0)) begin
                     pend_q <= 1'b1;
                     pend_op_q <= '{kind: OPK_CHIP, addr: '0, data: '0};
                     wel_q <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // Self-timed duration starts when the operation enters the FIFO
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tmr_q <= '0;
      end else if (push) begin
         case (pend_op_q.kind)
            OPK_SECTOR: tmr_q <= 32'(SEC_CYC);
            OPK_BLOCK: tmr_q <= 32'(BLK_CYC);
            OPK_CHIP: tmr_q <= 32'(CHIP_CYC);
            default: tmr_q <= 32'(PROG_CYC);
         endcase
      end else if (tmr_q != '0) begin
         tmr_q <= tmr_q - 32'h1;
      end
   end

   // ==========================================================
   // Operation buffer and outputs
   // ==========================================================
   sfc_fifo #(.W($bits(sfc_op_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .in_valid(pend_q),
      .in_ready(fifo_in_ready),
      .in_data(pend_op_q),
      .out_valid(fifo_out_valid),
      .out_ready(OP_READY),
      .out_data(OP_DATA)
   );

   assign OP_VALID = fifo_out_valid;
   assign SO = so_q;
   assign SO_OE = so_oe_q;
   assign MEM_RD_ADDR = addr_q;
   assign BUSY = busy;
   assign WRITE_ENABLE_LATCH = wel_q;
   assign AAI_ACTIVE = aai_q;

   // ==========================================================
   // Checks
   // ==========================================================
   wel_set_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      commit && (op_q == OPC_WRITE_ENABLE) && !aai_q |=> wel_q) else $error("latch not set");
   late_start_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $rose(pend_q) |-> $past(cs_rise) && $past(done_q)) else $error("operation started early");
   chip_prot_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $rose(pend_q) && (pend_op_q.kind == OPK_CHIP) |-> $past(PROT_MASK) == '0) else $error("chip erase while protected");
   read_inc_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      sck_fall && (state_q == SS_TX) && (txcnt_q == '0) && !is_status
      |=> addr_q == AW'($past(addr_q) + 1'b1)) else $error("read pointer did not advance");
   busy_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (tmr_q != '0) || pend_q |-> BUSY && status[STAT_BUSY_BIT]) else $error("busy dropped early");
   busy_pin_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      busy_ind |=> SO_OE && (SO == !$past(busy))) else $error("busy indication wrong");
   pin_release_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CS_N |=> !SO_OE) else $error("output driven while deselected");
   aai_exit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $fell(aai_q) |-> !wel_q) else $error("latch left set after word sequence");
   dummy_byte_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      byte_done && (state_q == SS_ADDR) && (acnt_q == ADDR_LAST) && (op_q == OPC_FAST_READ)
      |=> state_q == SS_DUMMY) else $error("fast read skipped dummy byte");

endmodule : sfc_core

// [bench/sfc_host_model.sv]
// ==========================================================
// Host controller driving the serial link, mode 0
// ==========================================================
module sfc_host_model (
   // Clock
   input wire logic clk,
   // Serial link
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Undriven pin has no pull: it reads as the inverse of its last level
   wire so_seen = so_oe ? so : !so;

   // Idle link: deselected, clock parked low
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // Select and shift n bits MSB first; SO taken just before each rise
   task automatic shift(input int n, input logic [63:0] tx, output logic [63:0] rx);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      rx = {63'h0, so_seen};
      for (int i = n - 1; i >= 0; i--) begin
         si <= tx[i];
         repeat (3) @(posedge clk);
         rx = {rx[62:0], so_seen};
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         sck <= 1'b0;
      end
   endtask : shift

   // Deselect; SI shows a changed level so a stale bit is never reused
   task automatic close();
      repeat (3) @(posedge clk);
      si <= ~si;
      cs_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : close
endmodule : sfc_host_model

// [bench/sfc_core_tb_top.sv]
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module sfc_core_tb_top import sfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, sck, cs_n, si, so, so_oe, op_valid, op_ready, busy, write_enable_latch, auto_increment_word_program;
   logic [19:0] mem_addr, a;
   logic [7:0] mem_data;
   logic [15:0] prot;
   logic [19:0] m;
   logic [63:0] rx;
   logic [7:0] eop [4] = '{8'hD8, 8'h20, 8'h60, 8'hC7};
   sfc_opk_t ek [4] = '{OPK_BLOCK, OPK_SECTOR, OPK_CHIP, OPK_CHIP};
   sfc_op_t op, opq [$];
   int seed = 17;
   int stall_seed = 17;
   int miscompares = 0;
   int n_tests = 0;

   // ==========================================================
   // Design, host and array backend
   // ==========================================================
   sfc_core #(.PROG_CYC(400), .SEC_CYC(500), .BLK_CYC(600), .CHIP_CYC(700)) sfc_core_inst (
      .CORE_CLK(clk), .RESET_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
      .MEM_RD_ADDR(mem_addr), .MEM_RD_DATA(mem_data), .OP_VALID(op_valid), .OP_READY(op_ready),
      .OP_DATA(op), .PROT_MASK(prot), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .AAI_ACTIVE(auto_increment_word_program));
   sfc_host_model sfc_host_model_inst (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

   function automatic logic [7:0] mem_of(input logic [19:0] x);
      return x[7:0] ^ x[19:12] ^ 8'hA5;
   endfunction : mem_of

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Array answers one cycle late; backend stalls at random
   always @(posedge clk) begin
      mem_data <= mem_of(mem_addr);
      op_ready <= 1'($random(stall_seed));
      if (op_valid && op_ready) opq.push_back(op);
   end

   task automatic cmd(input int n, input logic [63:0] tx);
      @(posedge clk);
      sfc_host_model_inst.shift(n, tx, rx);
      sfc_host_model_inst.close();
   endtask : cmd

   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 2000) tally_and_finish(1'b1);
   endtask : wait_idle

   task automatic exp_op(input sfc_opk_t k, input logic [23:0] ad, input logic [15:0] d);
      sfc_op_t o;
      o = '0;
      if (opq.size() != 0) o = opq.pop_front();
      `CHK(o, {k, ad, d})
   endtask : exp_op

   task automatic tally_and_finish(input bit late);
      if (late) miscompares++;
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      rst_n = 1'b0;
      prot = 16'h0000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK({busy, write_enable_latch, auto_increment_word_program, op_valid}, 4'h0)
      // Plain and fast reads, first one across the top address
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 20'hFFFFF : 20'($random(seed));
         cmd(48 + 8 * i[0], {(i[0] ? 8'h0B : 8'h03), 4'h0, a, 16'h0} << (8 * i[0]));
         `CHK(rx[15:0], {mem_of(a), mem_of(a + 20'h1)})
      end
      // Program refused without the latch, then accepted
      a = 20'($random(seed));
      cmd(40, {8'h02, 4'h0, a, a[7:0]});
      wait_idle();
      `CHK(opq.size(), 0)
      cmd(8, 64'h06);
      `CHK(write_enable_latch, 1'b1)
      @(posedge clk);
      sfc_host_model_inst.shift(40, {8'h02, 4'h0, a, a[7:0]}, rx);
      `CHK(busy, 1'b0)
      sfc_host_model_inst.close();
      cmd(24, {8'h05, 16'h0});
      `CHK({rx[8], rx[0]}, 2'h3)
      wait_idle();
      exp_op(OPK_BYTE, {4'h0, a}, {8'h00, a[7:0]});
      // Every erase code, protected target then open target
      for (int i = 0; i < 8; i++) begin
         if (!i[0]) a = 20'($random(seed));
         prot <= i[0] ? 16'h0 : (16'h1 << a[19:16]);
         m = (i < 2) ? 20'hF0000 : (i < 4) ? 20'hFF000 : 20'h0;
         cmd(8, 64'h06);
         cmd(i < 4 ? 32 : 8, {eop[i / 2], 4'h0, a} >> (i < 4 ? 0 : 24));
         wait_idle();
         if (i[0]) exp_op(ek[i / 2], {4'h0, a & m}, 16'h0);
         else `CHK(opq.size(), 0)
      end
      // Word sequence with busy shown on the serial output
      a = {a[19:1], 1'b0};
      cmd(8, 64'h70);
      cmd(8, 64'h06);
      cmd(48, {8'hAD, 4'h0, a, a[15:0]});
      cmd(0, 64'h0);
      `CHK({rx[0], so_oe, auto_increment_word_program}, 3'h1)
      wait_idle();
      exp_op(OPK_WORD, {4'h0, a}, a[15:0]);
      cmd(24, {8'hAD, ~a[15:0]});
      wait_idle();
      exp_op(OPK_WORD, {4'h0, a + 20'h2}, ~a[15:0]);
      cmd(0, 64'h0);
      `CHK(rx[0], 1'b1)
      cmd(32, {8'h20, 4'h0, a});
      wait_idle();
      `CHK(opq.size(), 0)
      cmd(8, 64'h04);
      `CHK(auto_increment_word_program, 1'b0)
      // Last word at the top address leaves the sequence
      cmd(8, 64'h06);
      cmd(48, {8'hAD, 4'h0, 20'hFFFFE, 16'hC35A});
      wait_idle();
      exp_op(OPK_WORD, 24'h0FFFFE, 16'hC35A);
      `CHK({auto_increment_word_program, write_enable_latch}, 2'h0)
      // Busy shown off: status data returns inside a word sequence
      cmd(8, 64'h80);
      cmd(8, 64'h06);
      cmd(48, {8'hAD, 4'h0, 20'h00000, 16'h1234}); // array blank since the chip erase
      wait_idle();
      exp_op(OPK_WORD, 24'h000000, 16'h1234);
      cmd(24, {8'h05, 16'h0});
      `CHK(rx[15:0], 16'h4242)
      cmd(8, 64'h04);
      cmd(24, {8'h05, 16'h0});
      `CHK(rx[15:0], 16'h0)
      tally_and_finish(1'b0);
   end
endmodule : sfc_core_tb_top
